/* design/wbl_pkg.sv */
// Constants for the work bit logic combiner: register map, fields,
// reset values, operation codes, source indices and timing counts.
// Assumes a 125 MHz controller clock and a 32-bit APB register bus.
package wbl_pkg;

    localparam int NUM_WB = 8;
    localparam int NUM_COND = 4;
    localparam int SRC_W = 6;
    localparam int OP_W = 3;
    localparam int DLY_W = 14;
    localparam int CFG_W = 10;
    localparam int STAT_W = 18;

    // Operation types
    localparam logic [OP_W-1:0] OP_OFF = 3'h0;
    localparam logic [OP_W-1:0] OP_AB_OR_CD = 3'h1;
    localparam logic [OP_W-1:0] OP_AC_AND_BD = 3'h2;
    localparam logic [OP_W-1:0] OP_ANY = 3'h3;
    localparam logic [OP_W-1:0] OP_ALL = 3'h4;

    // Register map (status byte address, word offsets inside a work bit slot)
    localparam logic [11:0] ADDR_STATUS = 12'h000;
    localparam logic [1:0] OFS_CFG = 2'h0;
    localparam logic [1:0] OFS_SRC = 2'h1;
    localparam logic [1:0] OFS_DLY = 2'h2;

    // Field positions
    localparam int CFG_OP_LSB = 0;
    localparam int CFG_POL_LSB = 4;
    localparam int CFG_OUTPOL_BIT = 8;
    localparam int CFG_UNIT_BIT = 9;
    localparam int SRC_FIELD_STRIDE = 8;
    localparam int DLY_ON_LSB = 0;
    localparam int DLY_OFF_LSB = 16;

    // Reset values and delay limit
    localparam logic [CFG_W-1:0] CFG_RST = 10'h000;
    localparam logic [SRC_W-1:0] SRC_RST = 6'h00;
    localparam logic [DLY_W-1:0] DLY_RST = 14'h0000;
    localparam logic [DLY_W-1:0] DLY_MAX = 14'h270F;

    // Source selector indices
    localparam int SRC_COUNT = 41;
    localparam int SRC_EVT_BASE = 3;
    localparam int SRC_ALM_BASE = 9;
    localparam int SRC_WB_BASE = 29;

    // Timing: delay units are seconds or minutes
    localparam int CLK_HZ = 125_000_000;
    localparam int SEC_S = 1;
    localparam int SEC_CYCLES = CLK_HZ * SEC_S;
    localparam logic [5:0] SEC_PER_MIN = 6'h3C;

endpackage

/* design/wb_delay_if.sv */
// Carrier between the combiner and one work bit delay stage.
// Assumes both ends share the controller clock.
`timescale 1ns/100ps
`default_nettype none
interface wb_delay_if;
    import wbl_pkg::*;
    logic raw;
    logic tick;
    logic [DLY_W-1:0] on_dly;
    logic [DLY_W-1:0] off_dly;
    logic out;
    modport ctrl (output raw, output tick, output on_dly, output off_dly,
        input out);
    modport dly (input raw, input tick, input on_dly, input off_dly,
        output out);
endinterface
`default_nettype wire

/* design/wb_delay.sv */
// ON/OFF delay stage for one work bit; its output is the registered result.
// Assumes tick pulses once per delay unit, one cycle wide.
`timescale 1ns/100ps
`default_nettype none
module wb_delay
    import wbl_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    wb_delay_if.dly port
);

    typedef struct packed {
        logic out;
        logic [DLY_W-1:0] cnt;
    } state_s;

    state_s s_reg;
    state_s s_next;
    logic differ;
    logic [DLY_W-1:0] lim;
    logic [DLY_W-1:0] cnt_inc;

    // First unit may be partial, so count one tick past the limit:
    // the delay errs long by under a unit, never short
    always_comb begin
        s_next = s_reg;
        differ = port.raw != s_reg.out;
        lim = port.raw ? port.on_dly : port.off_dly;
        cnt_inc = DLY_W'(s_reg.cnt + 1'b1);
        if (!differ) begin
            s_next.cnt = '0;
        end else if (port.tick) begin
            s_next.cnt = cnt_inc;
        end
        if (differ && (lim == '0 || (port.tick && cnt_inc > lim))) begin
            s_next.out = port.raw; // RULE9 RULE10
            s_next.cnt = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign port.out = s_reg.out;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    chk_on_delay_hold: assert property ( // RULE9
        $rose(port.out) |-> $past(port.on_dly) == '0
            || ($past(port.raw) && $past(port.tick)
            && $past(s_reg.cnt) >= $past(port.on_dly)))
        else $error("work bit turned on before its delay ran out");
    chk_off_delay_hold: assert property ( // RULE10
        $fell(port.out) |-> $past(port.off_dly) == '0
            || (!$past(port.raw) && $past(port.tick)
            && $past(s_reg.cnt) >= $past(port.off_dly)))
        else $error("work bit turned off before its delay ran out");
    chk_zero_delay_follow: assert property ( // RULE9
        (port.on_dly == '0 && port.off_dly == '0)
            |=> port.out == $past(port.raw))
        else $error("work bit did not follow input with no delay");

endmodule
`default_nettype wire

/* design/work_bit_logic_combiner.sv */
// Work bit logic combiner: eight configurable AND/OR work bits with APB
// registers. Assumes synchronous inputs on the 125 MHz controller clock.
//
// Overview of operation
// RULE1 - Eight independent work bits, each with own operation and four inputs
// RULE2 - Operation type picks one of four combiners or OFF, OFF by default
// RULE3 - Type 1: ON when (A and B) or (C and D)
// RULE4 - Type 2: ON when (A or C) and (B or D)
// RULE5 - Type 3: ON when any of A, B, C, D is ON
// RULE6 - Type 4: ON only when A, B, C and D are all ON
// RULE7 - Each condition input reads a selectable source, work bits included
// RULE8 - Each input and each result has normally open or closed polarity
// RULE9 - ON delay: output turns ON after input stayed ON for set time
// RULE10 - OFF delay: output turns OFF after input stayed OFF for set time
// RULE11 - All bits evaluated each cycle; results registered, fed back late
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module work_bit_logic_combiner
    import wbl_pkg::*;
#(
    parameter int SEC_CYCLES_P = SEC_CYCLES
) (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic [11:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [5:0] EVENT_IN,
    input wire logic [3:0] ALARM_IN,
    input wire logic [STAT_W-1:0] STAT_IN,
    output logic [NUM_WB-1:0] WORK_OUT
);

    typedef logic [NUM_COND-1:0][SRC_W-1:0] sel_t;

    typedef struct packed {
        logic [NUM_WB-1:0][CFG_W-1:0] cfg;
        logic [NUM_WB-1:0][NUM_COND*SRC_W-1:0] sel;
        logic [NUM_WB-1:0][DLY_W-1:0] on_dly;
        logic [NUM_WB-1:0][DLY_W-1:0] off_dly;
        logic [31:0] prdata;
        logic pslverr;
        logic pwr;
        logic [26:0] sec_cnt;
        logic [5:0] min_cnt;
    } state_s;

    state_s s_reg;
    state_s s_next;
    logic [SRC_COUNT-1:0] src_vec;
    logic [NUM_WB-1:0] wb_out;
    logic [NUM_WB-1:0] raw;
    logic [NUM_WB-1:0][NUM_COND-1:0] cond;
    logic sec_tick;
    logic min_tick;
    logic [3:0] wb_sel;
    logic [2:0] wb_i;
    logic is_status;
    logic is_wb;
    logic hit;
    logic [31:0] rd_data;
    logic [DLY_W-1:0] on_w;
    logic [DLY_W-1:0] off_w;

    // Gaps in the source list read as constant OFF
    always_comb begin
        src_vec = '0;
        src_vec[1] = 1'b1;
        src_vec[2] = s_reg.pwr;
        src_vec[SRC_EVT_BASE +: 6] = EVENT_IN;
        src_vec[SRC_ALM_BASE +: 4] = ALARM_IN;
        src_vec[15:13] = STAT_IN[2:0];
        src_vec[20:17] = STAT_IN[6:3];
        src_vec[28:22] = STAT_IN[13:7];
        src_vec[SRC_WB_BASE +: NUM_WB] = wb_out; // RULE11
        src_vec[40:37] = STAT_IN[17:14];
    end

    assign sec_tick = s_reg.sec_cnt == 27'(SEC_CYCLES_P - 1);
    assign min_tick = sec_tick && s_reg.min_cnt == SEC_PER_MIN - 6'h01;

    // APB decode: one 16-byte slot per work bit, slot 0 holds status
    assign wb_sel = PADDR[7:4];
    assign wb_i = 3'(wb_sel - 4'h1);
    assign is_status = PADDR == ADDR_STATUS;
    assign is_wb = PADDR[11:8] == 4'h0 && wb_sel != 4'h0
        && wb_sel <= 4'(NUM_WB) && PADDR[1:0] == 2'h0
        && PADDR[3:2] != 2'h3;
    assign hit = is_status || is_wb;
    assign on_w = PWDATA[DLY_ON_LSB +: DLY_W] > DLY_MAX
        ? DLY_MAX : PWDATA[DLY_ON_LSB +: DLY_W];
    assign off_w = PWDATA[DLY_OFF_LSB +: DLY_W] > DLY_MAX
        ? DLY_MAX : PWDATA[DLY_OFF_LSB +: DLY_W];

    always_comb begin
        rd_data = 32'h00000000;
        if (is_status) begin
            rd_data[NUM_WB-1:0] = wb_out;
        end else if (is_wb) begin
            case (PADDR[3:2])
                OFS_CFG: rd_data[CFG_W-1:0] = s_reg.cfg[wb_i];
                OFS_SRC: begin
                    for (int j = 0; j < NUM_COND; j++) begin
                        rd_data[j*SRC_FIELD_STRIDE +: SRC_W] =
                            s_reg.sel[wb_i][j*SRC_W +: SRC_W];
                    end
                end
                OFS_DLY: begin
                    rd_data[DLY_ON_LSB +: DLY_W] = s_reg.on_dly[wb_i];
                    rd_data[DLY_OFF_LSB +: DLY_W] = s_reg.off_dly[wb_i];
                end
                default: rd_data = 32'h00000000;
            endcase
        end
    end

    always_comb begin
        s_next = s_reg;
        s_next.pwr = 1'b0;
        s_next.sec_cnt = sec_tick ? 27'h0000000 : 27'(s_reg.sec_cnt + 1'b1);
        if (min_tick) begin
            s_next.min_cnt = 6'h00;
        end else if (sec_tick) begin
            s_next.min_cnt = 6'(s_reg.min_cnt + 1'b1);
        end
        // Read data and error are latched in setup so they leave a flop
        if (PSEL && !PENABLE) begin
            s_next.prdata = rd_data;
            s_next.pslverr = !hit;
        end
        if (PSEL && PENABLE && PWRITE && is_wb) begin
            case (PADDR[3:2])
                OFS_CFG: s_next.cfg[wb_i] = PWDATA[CFG_W-1:0];
                OFS_SRC: begin
                    for (int j = 0; j < NUM_COND; j++) begin
                        s_next.sel[wb_i][j*SRC_W +: SRC_W] =
                            PWDATA[j*SRC_FIELD_STRIDE +: SRC_W];
                    end
                end
                OFS_DLY: begin
                    s_next.on_dly[wb_i] = on_w;
                    s_next.off_dly[wb_i] = off_w;
                end
                default: s_next.pslverr = s_reg.pslverr;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            s_reg <= '0;
            s_reg.cfg <= {NUM_WB{CFG_RST}}; // RULE2
            s_reg.sel <= {(NUM_WB*NUM_COND){SRC_RST}};
            s_reg.on_dly <= {NUM_WB{DLY_RST}};
            s_reg.off_dly <= {NUM_WB{DLY_RST}};
            s_reg.pwr <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign PREADY = 1'b1;
    assign PRDATA = s_reg.prdata;
    assign PSLVERR = s_reg.pslverr;
    assign WORK_OUT = wb_out;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RESET);

    for (genvar i = 0; i < NUM_WB; i++) begin : g_wb // RULE1
        wb_delay_if dif ();
        logic [OP_W-1:0] op;
        logic [NUM_COND-1:0] pol;
        logic outpol;
        logic comb;
        sel_t sel;

        assign op = s_reg.cfg[i][CFG_OP_LSB +: OP_W];
        assign pol = s_reg.cfg[i][CFG_POL_LSB +: NUM_COND];
        assign outpol = s_reg.cfg[i][CFG_OUTPOL_BIT];
        assign sel = s_reg.sel[i];

        for (genvar j = 0; j < NUM_COND; j++) begin : g_cond
            assign cond[i][j] = (sel[j] < SRC_W'(SRC_COUNT)
                ? src_vec[sel[j]] : 1'b0) ^ pol[j]; // RULE7 RULE8
        end

        always_comb begin
            case (op)
                OP_AB_OR_CD: comb = (cond[i][0] && cond[i][1])
                    || (cond[i][2] && cond[i][3]); // RULE3
                OP_AC_AND_BD: comb = (cond[i][0] || cond[i][2])
                    && (cond[i][1] || cond[i][3]); // RULE4
                OP_ANY: comb = |cond[i]; // RULE5
                OP_ALL: comb = &cond[i]; // RULE6
                default: comb = 1'b0;
            endcase
        end

        // OFF is forced low: output polarity cannot turn it on
        assign raw[i] = (op == OP_OFF || op > OP_ALL)
            ? 1'b0 : comb ^ outpol; // RULE2 RULE8
        assign dif.raw = raw[i];
        assign dif.tick = s_reg.cfg[i][CFG_UNIT_BIT] ? min_tick : sec_tick;
        assign dif.on_dly = s_reg.on_dly[i];
        assign dif.off_dly = s_reg.off_dly[i];
        assign wb_out[i] = dif.out; // RULE11

        wb_delay u_dly (
            .clock(CLOCK),
            .reset(RESET),
            .port(dif.dly)
        );

        chk_off_forced: assert property ( // RULE2
            op == OP_OFF |-> !raw[i])
            else $error("work bit not off with no operation");
        chk_op_ab_cd: assert property ( // RULE3
            op == OP_AB_OR_CD && !outpol |-> raw[i] ==
            ((cond[i][0] && cond[i][1]) || (cond[i][2] && cond[i][3])))
            else $error("type 1 result wrong");
        chk_op_ac_bd: assert property ( // RULE4
            op == OP_AC_AND_BD |-> raw[i] == (outpol
            ^ ((cond[i][0] || cond[i][2]) && (cond[i][1] || cond[i][3]))))
            else $error("type 2 result wrong");
        chk_op_any: assert property ( // RULE5
            op == OP_ANY && !outpol |-> raw[i] == (cond[i] != 4'h0))
            else $error("type 3 result wrong");
        chk_op_all: assert property ( // RULE6
            op == OP_ALL && !outpol |-> raw[i] == (cond[i] == 4'hF))
            else $error("type 4 result wrong");
        chk_src_const: assert property ( // RULE7
            sel[0] == 6'h01 |-> cond[i][0] == !pol[0])
            else $error("always-on source not honoured");
        chk_feedback_delay: assert property ( // RULE11
            s_reg.on_dly[i] == '0 && s_reg.off_dly[i] == '0
            |=> src_vec[SRC_WB_BASE+i] == $past(raw[i]))
            else $error("work bit feedback not one cycle late");
    end

    // Sampled reset keeps the attempt at the release edge from firing
    chk_pwr_pulse: assert property ( // RULE7
        s_reg.pwr && !RESET |=> !s_reg.pwr)
        else $error("power-on source lasted more than a cycle");

    cov_all_on: cover property (g_wb[0].op == OP_ALL && raw[0]);
    cov_feedback: cover property (g_wb[1].sel[0] == 6'(SRC_WB_BASE)
        && raw[1]);
    cov_apb_write: cover property (PSEL && PENABLE && PWRITE && is_wb);
    cov_bad_addr: cover property (PSEL && PENABLE && PSLVERR);

endmodule
`default_nettype wire

/* tb/test_work_bit_logic_combiner.sv */
// Self-checking bench for the work bit logic combiner.
// Assumes an APB slave and a delay unit shortened to TICK clock cycles.
`timescale 1ns/100ps
`default_nettype none
module test_work_bit_logic_combiner;
    import wbl_pkg::*;
    // Short unit keeps even the minute scenario near a thousand cycles
    localparam int TICK = 10;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] event_in = 6'h00;
    logic [3:0] alarm_in = 4'h0;
    logic [STAT_W-1:0] stat_in = '0;
    logic [NUM_WB-1:0] work_out;
    int error_cnt = 0;
    int total_checks = 0;
    logic [31:0] rd;
    logic err;

    always #4 clock = ~clock;

    work_bit_logic_combiner #(.SEC_CYCLES_P(TICK)) work_bit_logic_combiner_i (
        .CLOCK(clock), .RESET(reset), .PADDR(paddr), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .EVENT_IN(event_in), .ALARM_IN(alarm_in), .STAT_IN(stat_in),
        .WORK_OUT(work_out));

    task test_done;
        $display("Checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; read data and error are taken at the ready edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            error_cnt++;
            test_done();
        end
    endtask

    function automatic logic [11:0] adr(input int n, input logic [1:0] o);
        return 12'(16 * n + 4 * o);
    endfunction

    function automatic logic src_val(input int i);
        if (i == 1) return 1'b1;
        if (i >= 3 && i <= 8) return event_in[i-3];
        if (i >= 9 && i <= 12) return alarm_in[i-9];
        if (i >= 13 && i <= 15) return stat_in[i-13];
        if (i >= 17 && i <= 20) return stat_in[i-14];
        if (i >= 22 && i <= 28) return stat_in[i-15];
        if (i >= 37 && i <= 40) return stat_in[i-23];
        return 1'b0;
    endfunction

    task settle;
        repeat (2) @(posedge clock);
        #1;
    endtask

    task drive_ev(input logic [5:0] v);
        @(posedge clock);
        event_in <= v;
        settle();
    endtask

    task reset_values;
        int n;
        @(posedge clock);
        #1;
        check("work_out", work_out, 0);
        for (n = 1; n <= NUM_WB; n++) begin
            apb(1'b0, adr(n, OFS_CFG), 0);
            check("cfg", rd, 32'(CFG_RST));
            apb(1'b0, adr(n, OFS_DLY), 0);
            check("dly", rd, 32'(DLY_RST));
        end
        apb(1'b0, 12'h090, 0);
        check("unmapped err", err, 1);
        check("unmapped data", rd, 0);
        apb(1'b1, ADDR_STATUS, 32'h0000_00FF);
        apb(1'b0, ADDR_STATUS, 0);
        check("status", rd, 0);
    endtask

    // Work bits 1..6 run ops 0..4 and 7 side by side on events 1..4
    task op_table;
        int n;
        int v;
        logic a, b, c, d;
        for (n = 0; n < 6; n++) begin
            apb(1'b1, adr(n + 1, OFS_SRC), 32'h0605_0403);
            apb(1'b1, adr(n + 1, OFS_CFG), (n < 5) ? n : 7);
        end
        for (v = 0; v < 16; v++) begin
            drive_ev(6'(v));
            {d, c, b, a} = 4'(v);
            check("op off", work_out[0], 0);
            check("op 1", work_out[1], (a & b) | (c & d));
            check("op 2", work_out[2], (a | c) & (b | d));
            check("op 3", work_out[3], a | b | c | d);
            check("op 4", work_out[4], a & b & c & d);
            check("op 7", work_out[5], 0);
        end
    endtask

    task polarity;
        apb(1'b1, adr(1, OFS_CFG), 32'h0000_0114);
        drive_ev(6'h0E);
        check("pol a out", work_out[0], 0);
        drive_ev(6'h0F);
        check("pol a out", work_out[0], 1);
        apb(1'b1, adr(1, OFS_CFG), 32'h0000_00F3);
        settle();
        check("pol all", work_out[0], 0);
        drive_ev(6'h0E);
        check("pol all", work_out[0], 1);
    endtask

    task sources;
        int i;
        int k;
        apb(1'b1, adr(1, OFS_CFG), 32'(OP_ANY));
        for (i = 0; i < 43; i++) begin
            if (i == 2 || (i >= SRC_WB_BASE && i < SRC_WB_BASE + 8)) continue;
            apb(1'b1, adr(1, OFS_SRC), 32'(i));
            for (k = 0; k < 2; k++) begin
                @(posedge clock);
                event_in <= k ? 6'h2A : 6'h15;
                alarm_in <= k ? 4'hA : 4'h5;
                stat_in <= k ? 18'h2AAAA : 18'h15555;
                settle();
                check("source", work_out[0], src_val(i));
            end
        end
    endtask

    // Chain work bit 1 -> 2 -> 3: each link costs exactly one edge
    task feedback;
        apb(1'b1, adr(1, OFS_SRC), 32'h0000_0003);
        apb(1'b1, adr(2, OFS_SRC), 32'(SRC_WB_BASE));
        apb(1'b1, adr(2, OFS_CFG), 32'(OP_ANY));
        apb(1'b1, adr(3, OFS_SRC), 32'(SRC_WB_BASE + 1));
        apb(1'b1, adr(3, OFS_CFG), 32'(OP_ANY));
        drive_ev(6'h00);
        check("chain idle", work_out[2:0], 0);
        @(posedge clock);
        event_in <= 6'h01;
        @(posedge clock);
        #1;
        check("chain 1", work_out[2:0], 3'h1);
        @(posedge clock);
        #1;
        check("chain 2", work_out[2:0], 3'h3);
        @(posedge clock);
        #1;
        check("chain 3", work_out[2:0], 3'h7);
    endtask

    task wait_out(input logic lvl, output int n);
        for (n = 0; n < 1300; n++) begin
            @(posedge clock);
            #1;
            if (work_out[0] === lvl) break;
        end
        if (n == 1300) begin
            error_cnt++;
            test_done();
        end
    endtask

    task delays;
        int n;
        logic seen;
        apb(1'b1, adr(8, OFS_DLY), 32'h2710_2710);
        apb(1'b0, adr(8, OFS_DLY), 0);
        check("dly clamp", rd, 32'h270F_270F);
        drive_ev(6'h00);
        apb(1'b1, adr(1, OFS_DLY), 32'h0002_0003);
        // A pulse shorter than the ON delay must never reach the output
        drive_ev(6'h01);
        @(posedge clock);
        event_in <= 6'h00;
        seen = 1'b0;
        repeat (5 * TICK) begin
            @(posedge clock);
            seen = seen | work_out[0];
        end
        check("on glitch", seen, 0);
        @(posedge clock);
        event_in <= 6'h01;
        wait_out(1'b1, n);
        check("on delay", n >= 3 * TICK && n <= 4 * TICK, 1);
        @(posedge clock);
        event_in <= 6'h00;
        wait_out(1'b0, n);
        check("off delay", n >= 2 * TICK && n <= 3 * TICK, 1);
    endtask

    // One minute ON delay on the minute unit: sixty shortened seconds
    task minutes;
        int n;
        apb(1'b1, adr(1, OFS_CFG), 32'h0000_0203);
        apb(1'b1, adr(1, OFS_DLY), 32'h0000_0001);
        @(posedge clock);
        event_in <= 6'h01;
        wait_out(1'b1, n);
        check("minute delay", n >= 60 * TICK && n <= 120 * TICK, 1);
    endtask

    initial begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        reset_values();
        op_table();
        polarity();
        sources();
        feedback();
        delays();
        minutes();
        test_done();
    end
endmodule
`default_nettype wire
